// File: core/sdcbk_cfg.svh
`ifndef SDCBK_CFG_SVH
`define SDCBK_CFG_SVH
`define SDCBK_NBANK 4
`define SDCBK_ROW_W 12
`define SDCBK_COL_W 8
`define SDCBK_AP_BIT 10
`define SDCBK_DQM_LAT 2
`define SDCBK_BURST_MAX 8'hFF
`endif

// File: core/sdcbk_core.sv
`include "sdcbk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdcbk_core #(
    parameter int BURST_LEN = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_address_lines,
    input wire logic [11:0] addr,
    input wire logic [3:0] byte_lane_masks,
    output logic [3:0] bank_open,
    output logic [47:0] open_rows,
    output logic col_valid,
    output logic col_write,
    output logic col_auto_pre,
    output logic [1:0] col_bank,
    output logic [7:0] col_addr,
    output logic [3:0] wr_lane_en,
    output logic [3:0] rd_lane_en,
    output logic burst_active,
    output logic burst_stopped,
    output logic suspended,
    output logic powered_down
);
    if (BURST_LEN < 1 || BURST_LEN > 256) begin : g_bad_len
        $error("BURST_LEN out of range");
    end
    typedef struct packed {
        logic cke_prev;
        sdcbk_pkg::sdcbk_mode_t mode;
        logic [3:0] open;
        logic [47:0] rows;
        logic cv;
        logic cw;
        logic cap;
        logic [1:0] cb;
        logic [7:0] ca;
        logic [3:0] wlane;
        logic [3:0] m1;
        logic [3:0] m2;
        logic [7:0] bcnt;
        logic bstop;
    } sdcbk_st_t;
    sdcbk_st_t st_reg, st_next;
    sdcbk_pkg::sdcbk_cmd_t cmd;
    logic [7:0] blen;
    assign blen = 8'(BURST_LEN - 1);
    sdcbk_decode u_dec (
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .addr(addr),
        .cmd(cmd)
    );
    logic run_now;
    logic nop_like;
    logic burst_last;
    assign nop_like = (cmd == sdcbk_pkg::SDCBK_C_DESEL) || (cmd == sdcbk_pkg::SDCBK_C_NOP);
    assign run_now = (st_reg.mode == sdcbk_pkg::SDCBK_RUN) && st_reg.cke_prev;
    // Last running cycle of a burst; the first cycle is the column pulse itself
    assign burst_last = st_reg.cv ? (st_reg.bcnt == 8'h00) : (st_reg.bcnt == 8'h01);
    always_comb begin
        st_next = st_reg;
        st_next.cke_prev = cke;
        st_next.cv = 1'b0;
        st_next.bstop = 1'b0;
        case (st_reg.mode)
            sdcbk_pkg::SDCBK_RUN: begin
                if (!cke) begin
                    if (st_reg.cv || st_reg.bcnt != 8'h00 || (|st_reg.open)) begin
                        st_next.mode = sdcbk_pkg::SDCBK_SUSP;
                    end else if (nop_like) begin
                        st_next.mode = sdcbk_pkg::SDCBK_PDN;
                    end else if (cmd == sdcbk_pkg::SDCBK_C_REF) begin
                        st_next.mode = sdcbk_pkg::SDCBK_SREF;
                    end else begin
                        st_next.mode = sdcbk_pkg::SDCBK_PDN;
                    end
                end
            end
            sdcbk_pkg::SDCBK_SUSP: begin
                if (cke) st_next.mode = sdcbk_pkg::SDCBK_RUN;
            end
            sdcbk_pkg::SDCBK_PDN, sdcbk_pkg::SDCBK_SREF: begin
                if (cke && nop_like) st_next.mode = sdcbk_pkg::SDCBK_RUN;
            end
            default: st_next.mode = sdcbk_pkg::SDCBK_RUN;
        endcase
        if (st_reg.mode != sdcbk_pkg::SDCBK_SUSP) begin
            st_next.m1 = byte_lane_masks;
            st_next.m2 = st_reg.m1;
            if (st_reg.bcnt != 8'h00 && !st_reg.cv) begin
                st_next.bcnt = st_reg.bcnt - 8'h01;
            end
            if (burst_last && st_reg.cap) st_next.open[st_reg.cb] = 1'b0;
        end
        st_next.wlane = ~byte_lane_masks;
        if (run_now) begin
            case (cmd)
                sdcbk_pkg::SDCBK_C_ACT: begin
                    if (!st_reg.open[bank_address_lines]) begin
                        st_next.open[bank_address_lines] = 1'b1;
                        st_next.rows[bank_address_lines*12 +: 12] = addr;
                    end
                end
                sdcbk_pkg::SDCBK_C_PRE: st_next.open[bank_address_lines] = 1'b0;
                sdcbk_pkg::SDCBK_C_PREA: st_next.open = 4'h0;
                sdcbk_pkg::SDCBK_C_RD, sdcbk_pkg::SDCBK_C_WR: begin
                    if (st_reg.open[bank_address_lines]) begin
                        st_next.cv = 1'b1;
                        st_next.cw = (cmd == sdcbk_pkg::SDCBK_C_WR);
                        st_next.cap = addr[`SDCBK_AP_BIT];
                        st_next.cb = bank_address_lines;
                        st_next.ca = addr[7:0];
                        st_next.bcnt = (BURST_LEN == 256) ? `SDCBK_BURST_MAX : blen;
                        if (cmd == sdcbk_pkg::SDCBK_C_WR) st_next.wlane = ~byte_lane_masks;
                    end
                end
                sdcbk_pkg::SDCBK_C_BST: begin
                    if (st_reg.bcnt != 8'h00 || st_reg.cv) begin
                        st_next.bcnt = 8'h00;
                        st_next.bstop = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (st_reg.mode == sdcbk_pkg::SDCBK_SUSP) begin
            st_next.bcnt = st_reg.bcnt;
            st_next.m1 = st_reg.m1;
            st_next.m2 = st_reg.m2;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.mode <= sdcbk_pkg::SDCBK_RUN;
            st_reg.wlane <= 4'hF;
        end else begin
            st_reg <= st_next;
        end
    end
    assign bank_open = st_reg.open;
    assign open_rows = st_reg.rows;
    assign col_valid = st_reg.cv;
    assign col_write = st_reg.cw;
    assign col_auto_pre = st_reg.cap;
    assign col_bank = st_reg.cb;
    assign col_addr = st_reg.ca;
    assign wr_lane_en = st_reg.wlane;
    assign rd_lane_en = ~st_reg.m2;
    assign burst_active = st_reg.cv || (st_reg.bcnt != 8'h00);
    assign burst_stopped = st_reg.bstop;
    assign suspended = (st_reg.mode == sdcbk_pkg::SDCBK_SUSP);
    assign powered_down = (st_reg.mode == sdcbk_pkg::SDCBK_PDN);

    row_open_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_now && cmd == sdcbk_pkg::SDCBK_C_ACT && !bank_open[bank_address_lines]
        |=> bank_open[$past(bank_address_lines)]
            && open_rows[$past(bank_address_lines)*12 +: 12] == $past(addr))
        else $error("row open failed");
    bank_close_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_now && cmd == sdcbk_pkg::SDCBK_C_PRE |=> !bank_open[$past(bank_address_lines)])
        else $error("bank close failed");
    all_close_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_now && cmd == sdcbk_pkg::SDCBK_C_PREA |=> bank_open == 4'h0)
        else $error("all close failed");
    desel_ignore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_now && cs_n && !burst_active |=> !col_valid && $stable(bank_open))
        else $error("deselect not ignored");
    auto_pre_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        col_valid |-> col_auto_pre == $past(addr[`SDCBK_AP_BIT]) && col_addr == $past(addr[7:0]))
        else $error("column fields wrong");
    suspend_entry_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        run_now && !cke && burst_active |=> suspended)
        else $error("suspend not entered");
    suspend_exit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        suspended && cke |=> !suspended)
        else $error("suspend not left");
    pdn_exit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        powered_down && cke && !cs_n && ras_n && cas_n && we_n |=> !powered_down)
        else $error("power-down not left");
    mask_lat_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !suspended ##1 !suspended |=> rd_lane_en == ~$past(byte_lane_masks, 2))
        else $error("read mask latency wrong");
    bst_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        burst_stopped |-> $past(burst_active))
        else $error("burst stop without burst");
    cov_rd_c: cover property (@(posedge ref_clk) col_valid && !col_write);
    cov_wr_c: cover property (@(posedge ref_clk) col_valid && col_write);
    cov_susp_c: cover property (@(posedge ref_clk) suspended ##1 !suspended);
    cov_pdn_c: cover property (@(posedge ref_clk) powered_down ##1 !powered_down);
    cov_bsusp_c: cover property (@(posedge ref_clk) suspended && burst_active);
endmodule : sdcbk_core
`default_nettype wire

// File: core/sdcbk_decode.sv
`include "sdcbk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdcbk_decode (
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    output sdcbk_pkg::sdcbk_cmd_t cmd
);
    always_comb begin
        if (cs_n) begin
            cmd = sdcbk_pkg::SDCBK_C_DESEL;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h3: cmd = sdcbk_pkg::SDCBK_C_ACT;
                3'h2: cmd = addr[`SDCBK_AP_BIT] ? sdcbk_pkg::SDCBK_C_PREA
                                                : sdcbk_pkg::SDCBK_C_PRE;
                3'h5: cmd = sdcbk_pkg::SDCBK_C_RD;
                3'h4: cmd = sdcbk_pkg::SDCBK_C_WR;
                3'h6: cmd = sdcbk_pkg::SDCBK_C_BST;
                3'h0: cmd = sdcbk_pkg::SDCBK_C_MRS;
                3'h1: cmd = sdcbk_pkg::SDCBK_C_REF;
                default: cmd = sdcbk_pkg::SDCBK_C_NOP;
            endcase
        end
    end
endmodule : sdcbk_decode
`default_nettype wire

// File: core/sdcbk_pkg.sv
`default_nettype none
package sdcbk_pkg;
    typedef enum logic [3:0] {
        SDCBK_RUN = 4'h1,
        SDCBK_SUSP = 4'h2,
        SDCBK_PDN = 4'h4,
        SDCBK_SREF = 4'h8
    } sdcbk_mode_t;
    typedef enum logic [3:0] {
        SDCBK_C_NOP, SDCBK_C_ACT, SDCBK_C_PRE, SDCBK_C_PREA, SDCBK_C_RD,
        SDCBK_C_WR, SDCBK_C_BST, SDCBK_C_MRS, SDCBK_C_REF, SDCBK_C_DESEL
    } sdcbk_cmd_t;
endpackage : sdcbk_pkg
`default_nettype wire

// File: testbench/sdcbk_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdcbk_core_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] masks = 4'h0;
    wire logic cke;
    wire logic [3:0] cmd_n;
    wire logic [1:0] ba;
    wire logic [11:0] addr;
    logic [3:0] bank_open, wr_en, rd_en;
    logic [47:0] rows;
    logic cv, cw, cap, bact, bst, susp, pdn;
    logic [1:0] cb;
    logic [7:0] ca;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    sdcbk_ctrl_model i_sdcbk_ctrl_model (.ref_clk(ref_clk), .cke(cke), .cmd_n(cmd_n),
        .bank_address_lines(ba), .addr(addr));
    sdcbk_core #(.BURST_LEN(4)) i_sdcbk_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cke(cke), .cs_n(cmd_n[3]), .ras_n(cmd_n[2]), .cas_n(cmd_n[1]), .we_n(cmd_n[0]),
        .bank_address_lines(ba), .addr(addr), .byte_lane_masks(masks),
        .bank_open(bank_open), .open_rows(rows), .col_valid(cv), .col_write(cw),
        .col_auto_pre(cap), .col_bank(cb), .col_addr(ca), .wr_lane_en(wr_en),
        .rd_lane_en(rd_en), .burst_active(bact), .burst_stopped(bst),
        .suspended(susp), .powered_down(pdn));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic t_open();
        i_sdcbk_ctrl_model.issue(4'h3, 2'h1, 12'hA5C);
        chk(rows[23:12], 12'hA5C);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h2, 12'h3F1);
        chk(bank_open, 4'h6);
        i_sdcbk_ctrl_model.issue(4'hB, 2'h0, 12'h123);
        chk(bank_open, 4'h6);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h1, 12'h001);
        chk(rows[23:12], 12'hA5C);
        $display("open done");
    endtask : t_open
    task automatic t_col();
        i_sdcbk_ctrl_model.issue(4'h5, 2'h1, 12'hB3C);
        chk({cv, cw, cap, cb, ca}, {3'h4, 2'h1, 8'h3C});
        i_sdcbk_ctrl_model.issue(4'h6, 2'h0, 12'h000);
        chk(bst, 1'b1);
        repeat (8) @(negedge ref_clk);
        i_sdcbk_ctrl_model.issue(4'h6, 2'h0, 12'h000);
        chk(bst, 1'b0);
        i_sdcbk_ctrl_model.issue(4'h4, 2'h2, 12'h4FF);
        chk({cv, cw, cap, cb, ca}, {3'h7, 2'h2, 8'hFF});
        chk(wr_en, 4'hF);
        repeat (10) @(negedge ref_clk);
        chk(bank_open, 4'h2);
        $display("column done");
    endtask : t_col
    task automatic t_mask();
        @(negedge ref_clk);
        masks = 4'h5;
        @(negedge ref_clk);
        chk(wr_en, 4'hA);
        chk(rd_en, 4'hF);
        repeat (2) @(negedge ref_clk);
        chk(rd_en, 4'hA);
        masks = 4'h0;
        @(negedge ref_clk);
        chk(wr_en, 4'hF);
        chk(rd_en, 4'hA);
        $display("mask done");
    endtask : t_mask
    task automatic t_modes();
        i_sdcbk_ctrl_model.set_cke(1'b0);
        chk(susp, 1'b1);
        i_sdcbk_ctrl_model.set_cke(1'b1);
        chk(susp, 1'b0);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h3, 12'h777);
        i_sdcbk_ctrl_model.issue(4'h2, 2'h1, 12'h000);
        chk(bank_open, 4'h8);
        i_sdcbk_ctrl_model.issue(4'h2, 2'h0, 12'h400);
        chk(bank_open, 4'h0);
        i_sdcbk_ctrl_model.set_cke(1'b0);
        chk({pdn, susp}, 2'h2);
        i_sdcbk_ctrl_model.set_cke(1'b1);
        chk(pdn, 1'b0);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h1, 12'h5A3);
        chk(rows[23:12], 12'h5A3);
        $display("modes done");
    endtask : t_modes
    task automatic t_burst();
        i_sdcbk_ctrl_model.issue(4'h5, 2'h1, 12'h010);
        i_sdcbk_ctrl_model.set_cke(1'b0);
        chk({susp, bact}, 2'h3);
        repeat (4) @(negedge ref_clk);
        chk({susp, bact}, 2'h3);
        i_sdcbk_ctrl_model.set_cke(1'b1);
        chk({susp, bact}, 2'h1);
        @(negedge ref_clk);
        chk(bact, 1'b0);
        $display("burst suspend done");
    endtask : t_burst
    task automatic t_sref();
        i_sdcbk_ctrl_model.issue(4'h2, 2'h0, 12'h400);
        i_sdcbk_ctrl_model.enter_low(4'h1);
        chk({pdn, susp, bank_open}, 6'h00);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h0, 12'h0AA);
        chk(bank_open, 4'h0);
        i_sdcbk_ctrl_model.set_cke(1'b1);
        i_sdcbk_ctrl_model.issue(4'h3, 2'h0, 12'h0AA);
        chk({bank_open, rows[11:0]}, 16'h10AA);
        $display("self refresh done");
    endtask : t_sref
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_open();
        t_col();
        t_mask();
        t_modes();
        t_burst();
        t_sref();
        report_and_stop();
    end
endmodule : sdcbk_core_tb
`default_nettype wire

// File: testbench/sdcbk_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdcbk_ctrl_model #(
    parameter int T_RCD = 3,
    parameter int T_RC = 10,
    parameter int T_RRD = 2
) (
    input wire logic ref_clk,
    output logic cke,
    output logic [3:0] cmd_n,
    output logic [1:0] bank_address_lines,
    output logic [11:0] addr
);
    int cyc = 0;
    int act_at [4] = '{default: -100};
    int any_act = -100;
    initial begin
        cke = 1'b1;
        cmd_n = 4'h7;
        bank_address_lines = 2'h0;
        addr = 12'h000;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        @(negedge ref_clk);
        if (c == 4'h3) begin
            while (cyc - act_at[b] < T_RC || cyc - any_act < T_RRD) @(negedge ref_clk);
            act_at[b] = cyc;
            any_act = cyc;
        end
        if (c[3:1] == 3'h2) begin
            while (cyc - act_at[b] < T_RCD) @(negedge ref_clk);
        end
        cmd_n = c;
        bank_address_lines = b;
        addr = a;
        @(negedge ref_clk);
        cmd_n = 4'h7;
        bank_address_lines = ~b;
        addr = ~a;
    endtask : issue
    task automatic enter_low(input logic [3:0] c);
        @(negedge ref_clk);
        cke = 1'b0;
        cmd_n = c;
        @(negedge ref_clk);
        cmd_n = 4'h7;
        @(negedge ref_clk);
    endtask : enter_low
    task automatic set_cke(input logic k);
        @(negedge ref_clk);
        cke = k;
        repeat (2) @(negedge ref_clk);
    endtask : set_cke
endmodule : sdcbk_ctrl_model
`default_nettype wire
